// File: core/isse_eval.sv
/*
  isse_eval: incremental speed sensor evaluator, top level.
  Assumes tracks A/B from an encoder, a static mode and division mark setting
  held by control software, and one 50 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module isse_eval #(
  parameter int SAMPLE_CYCLES = isse_pkg::SAMPLE_PERIOD
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic speed_track_a_input,
  input wire logic speed_track_b_input,
  input wire logic [6:0] sensor_mode,
  input wire logic marks_load,
  input wire logic [13:0] marks_value,
  output logic [13:0] division_marks,
  output logic track_a_free,
  output logic track_b_free,
  output logic signed [isse_pkg::COUNT_W-1:0] edge_count,
  output logic signed [isse_pkg::SAMPLE_W-1:0] sample_delta,
  output logic sample_valid,
  output logic mode_bad
);
  typedef struct packed {
    logic a_d;
    logic b_d;
    logic [13:0] marks;
    logic signed [isse_pkg::COUNT_W-1:0] count;
    logic signed [isse_pkg::COUNT_W-1:0] last;
    logic signed [isse_pkg::SAMPLE_W-1:0] delta;
    logic [31:0] timer;
    logic valid;
  } isse_state_t;

  isse_state_t st_r;
  isse_state_t st_nxt;
  logic [1:0] trk;
  logic a_s;
  logic b_s;
  logic a_rise;
  logic a_fall;
  logic b_edge;
  logic two_ch;
  logic one_ch;
  logic quad;
  logic dbl;
  logic invert;
  logic negative;
  logic known;
  logic step;
  logic dir_up;
  logic signed [isse_pkg::COUNT_W-1:0] diff;

  // synchronise both tracks before any edge logic sees them
  isse_sync #(.WIDTH(2)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({speed_track_b_input, speed_track_a_input}),
    .q(trk)
  );
  assign a_s = trk[0];
  assign b_s = trk[1];

  // mode decode; unknown codes behave as off and raise mode_bad
  always_comb begin
    two_ch = 1'b0;
    one_ch = 1'b0;
    quad = 1'b0;
    dbl = 1'b0;
    invert = 1'b0;
    negative = 1'b0;
    known = 1'b1;
    case (sensor_mode)
      isse_pkg::MODE_OFF: known = 1'b1;
      isse_pkg::MODE_SINGLE: two_ch = 1'b1;
      isse_pkg::MODE_QUAD: begin
        two_ch = 1'b1;
        quad = 1'b1;
      end
      isse_pkg::MODE_A_SINGLE: one_ch = 1'b1;
      isse_pkg::MODE_A_DOUBLE: begin
        one_ch = 1'b1;
        dbl = 1'b1;
      end
      isse_pkg::MODE_SINGLE_INV: begin
        two_ch = 1'b1;
        invert = 1'b1;
      end
      isse_pkg::MODE_QUAD_INV: begin
        two_ch = 1'b1;
        quad = 1'b1;
        invert = 1'b1;
      end
      isse_pkg::MODE_A_SINGLE_NEG: begin
        one_ch = 1'b1;
        negative = 1'b1;
      end
      isse_pkg::MODE_A_DOUBLE_NEG: begin
        one_ch = 1'b1;
        dbl = 1'b1;
        negative = 1'b1;
      end
      default: known = 1'b0;
    endcase
  end

  assign a_rise = a_s & ~st_r.a_d;
  assign a_fall = ~a_s & st_r.a_d;
  assign b_edge = b_s ^ st_r.b_d;

  // edge qualification and direction; in single evaluation only A rising counts,
  // so B low at A rise means A leads B (forward)
  always_comb begin
    step = 1'b0;
    dir_up = 1'b1;
    if (two_ch) begin
      if (quad) begin
        step = a_rise | a_fall | b_edge;
        // A edge with A != B, or B edge with A == B, means A leads
        if (a_rise | a_fall) begin
          dir_up = (a_s != b_s);
        end else begin
          dir_up = (a_s == b_s);
        end
      end else begin
        step = a_rise;
        dir_up = ~b_s;
      end
      if (invert) begin
        dir_up = ~dir_up;
      end
    end else if (one_ch) begin
      step = dbl ? (a_rise | a_fall) : a_rise;
      dir_up = ~negative;
    end
  end

  assign diff = st_r.count - st_r.last;

  // next state: counter, marks setting and periodic sample
  always_comb begin
    st_nxt = st_r;
    st_nxt.a_d = a_s;
    st_nxt.b_d = b_s;
    st_nxt.valid = 1'b0;
    if (marks_load && marks_value >= isse_pkg::MARKS_MIN
        && marks_value <= isse_pkg::MARKS_MAX) begin
      st_nxt.marks = marks_value;
    end
    if (step) begin
      st_nxt.count = dir_up ? st_r.count + 1 : st_r.count - 1;
    end
    if (st_r.timer == 32'(SAMPLE_CYCLES - 1)) begin
      st_nxt.timer = '0;
      st_nxt.last = st_r.count;
      st_nxt.delta = diff[isse_pkg::SAMPLE_W-1:0];
      st_nxt.valid = 1'b1;
    end else begin
      st_nxt.timer = st_r.timer + 32'h00000001;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.marks <= isse_pkg::MARKS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // track release follows the mode: off frees both, one-channel frees B
  assign track_a_free = ~(two_ch | one_ch);
  assign track_b_free = ~two_ch;
  assign mode_bad = ~known;
  assign division_marks = st_r.marks;
  assign edge_count = st_r.count;
  assign sample_delta = st_r.delta;
  assign sample_valid = st_r.valid;

  a_off_no_count: assert property (@(posedge mclk) disable iff (!reset_n)
    (sensor_mode == isse_pkg::MODE_OFF) |=> $stable(edge_count) || $past(step))
    else $error("count moved in off mode");
  a_off_frees: assert property (@(posedge mclk) disable iff (!reset_n)
    (sensor_mode == isse_pkg::MODE_OFF) |-> track_a_free && track_b_free)
    else $error("off mode holds a track");
  a_single_fwd: assert property (@(posedge mclk) disable iff (!reset_n)
    (sensor_mode == isse_pkg::MODE_SINGLE && a_rise && !b_s) |=>
    edge_count == $past(edge_count) + 1)
    else $error("single mode forward step wrong");
  a_quad_steps: assert property (@(posedge mclk) disable iff (!reset_n)
    (sensor_mode == isse_pkg::MODE_QUAD && b_edge && !a_rise && !a_fall) |=>
    edge_count != $past(edge_count))
    else $error("quad mode missed track B edge");
  a_a_only_pos: assert property (@(posedge mclk) disable iff (!reset_n)
    (sensor_mode == isse_pkg::MODE_A_SINGLE) |=> edge_count >= $past(edge_count))
    else $error("single channel count went down");
  a_double_fall: assert property (@(posedge mclk) disable iff (!reset_n)
    (sensor_mode == isse_pkg::MODE_A_DOUBLE && a_fall) |=>
    edge_count == $past(edge_count) + 1)
    else $error("double mode missed falling edge");
  a_inv_single: assert property (@(posedge mclk) disable iff (!reset_n)
    (sensor_mode == isse_pkg::MODE_SINGLE_INV && a_rise && !b_s) |=>
    edge_count == $past(edge_count) - 1)
    else $error("inverted mode sign wrong");
  a_neg_only: assert property (@(posedge mclk) disable iff (!reset_n)
    (sensor_mode == isse_pkg::MODE_A_DOUBLE_NEG) |=> edge_count <= $past(edge_count))
    else $error("negative mode count went up");
  a_marks_range: assert property (@(posedge mclk) disable iff (!reset_n)
    division_marks >= isse_pkg::MARKS_MIN && division_marks <= isse_pkg::MARKS_MAX)
    else $error("division marks out of range");
endmodule : isse_eval
`default_nettype wire

// File: core/isse_sync.sv
/*
  isse_sync: two-flop synchroniser for the two track inputs.
  Assumes tracks arrive asynchronously; first stage is read only by the second.
*/
`timescale 1ns/100ps
`default_nettype none
module isse_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } isse_sync_t;
  isse_sync_t st_r;
  isse_sync_t st_nxt;

  // shift stage one into stage two
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule : isse_sync
`default_nettype wire

// File: inc/isse_pkg.sv
/*
  isse_pkg: constants of the incremental speed sensor evaluator.
  Assumes one system clock; mode codes are the numeric settings of the sensor mode input.
*/
package isse_pkg;
  // sensor mode codes
  localparam logic [6:0] MODE_OFF = 7'h00;
  localparam logic [6:0] MODE_SINGLE = 7'h01;
  localparam logic [6:0] MODE_QUAD = 7'h04;
  localparam logic [6:0] MODE_A_SINGLE = 7'h0B;
  localparam logic [6:0] MODE_A_DOUBLE = 7'h0C;
  localparam logic [6:0] MODE_SINGLE_INV = 7'h65;
  localparam logic [6:0] MODE_QUAD_INV = 7'h68;
  localparam logic [6:0] MODE_A_SINGLE_NEG = 7'h6F;
  localparam logic [6:0] MODE_A_DOUBLE_NEG = 7'h70;
  // division marks
  localparam logic [13:0] MARKS_MIN = 14'h0001;
  localparam logic [13:0] MARKS_MAX = 14'h2000;
  localparam logic [13:0] MARKS_RESET = 14'h0400;
  // widths and sampling
  localparam int COUNT_W = 32;
  localparam int SAMPLE_PERIOD = 50000;
  localparam int SAMPLE_W = 16;
endpackage : isse_pkg

// File: verif/isse_enc.sv
/*
  isse_enc: behavioural two-track incremental encoder.
  Assumes one step pulse per move, spaced by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module isse_enc (
  input wire logic mclk,
  input wire logic step,
  input wire logic dir,
  output logic track_a,
  output logic track_b
);
  logic [1:0] ph = 2'h0;
  // gray walk: one track moves per step, so no double edge
  always @(posedge mclk) if (step) ph <= dir ? ph + 2'h1 : ph - 2'h1;
  // forward lets track a lead track b
  assign track_a = ph == 2'h1 || ph == 2'h2;
  assign track_b = ph[1];
endmodule : isse_enc
`default_nettype wire

// File: verif/isse_eval_tb.sv
/*
  isse_eval_tb: self-checking bench for the speed sensor evaluator.
  Assumes the encoder model and a short sample period.
*/
`timescale 1ns/100ps
`default_nettype none
module isse_eval_tb;
  logic mclk = 1'b0, reset_n = 1'b0, step = 1'b0, dir = 1'b0, marks_load = 1'b0;
  logic [6:0] sensor_mode = 7'h00, md [10];
  logic [13:0] marks_value = 14'h0000, division_marks, mk_in [5], mk_ex [5];
  logic trk_a, trk_b, track_a_free, track_b_free, sample_valid, mode_bad;
  logic signed [31:0] edge_count, last = 32'sh0, q [$];
  logic signed [15:0] sample_delta;
  int errors = 0, n_checks = 0, ex = 0, ph = 0;
  initial forever #10 mclk = ~mclk;
  isse_enc ENC (.mclk(mclk), .step(step), .dir(dir), .track_a(trk_a), .track_b(trk_b));
  isse_eval #(.SAMPLE_CYCLES(16)) DUT (.mclk(mclk), .reset_n(reset_n),
    .speed_track_a_input(trk_a), .speed_track_b_input(trk_b), .sensor_mode(sensor_mode),
    .marks_load(marks_load), .marks_value(marks_value), .division_marks(division_marks),
    .track_a_free(track_a_free), .track_b_free(track_b_free), .edge_count(edge_count),
    .sample_delta(sample_delta), .sample_valid(sample_valid), .mode_bad(mode_bad));
  task automatic wrap_up;
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_cnt
  task automatic chk_val(input logic [13:0] got, input logic [13:0] exp);
    chk_cnt({18'h00000, got}, {18'h00000, exp});
  endtask : chk_val
  // inputs move 2 ns after the edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc
  // count change of one encoder step, from the mode table
  function automatic int dlt(input logic [6:0] m, input int p, input logic d);
    logic ao, bo, an;
    int s;
    ao = p == 1 || p == 2;
    bo = p >= 2;
    an = ((d ? p + 1 : p + 3) % 4) inside {1, 2};
    case (m)
      isse_pkg::MODE_QUAD, isse_pkg::MODE_QUAD_INV: s = d ? 1 : -1;
      isse_pkg::MODE_SINGLE, isse_pkg::MODE_SINGLE_INV: s = (!ao && an) ? (bo ? -1 : 1) : 0;
      isse_pkg::MODE_A_SINGLE, isse_pkg::MODE_A_SINGLE_NEG: s = !ao && an;
      isse_pkg::MODE_A_DOUBLE, isse_pkg::MODE_A_DOUBLE_NEG: s = ao != an;
      default: s = 0;
    endcase
    return m >= 7'h65 ? -s : s;
  endfunction : dlt
  // one encoder step; a counted edge leaves a note
  task automatic mv(input logic d);
    ex += dlt(sensor_mode, ph, d);
    if (dlt(sensor_mode, ph, d) != 0) q.push_back(ex);
    ph = (d ? ph + 1 : ph + 3) % 4;
    dir = d;
    step = 1'b1;
    cyc(1);
    step = 1'b0;
    cyc(6);
  endtask : mv
  task automatic rst(input logic [6:0] m);
    reset_n = 1'b0;
    sensor_mode = m;
    ex = 0;
    cyc(12);
    reset_n = 1'b1;
    cyc(2);
  endtask : rst
  // each change of the count is matched with the oldest note
  always @(posedge mclk) begin
    #1;
    if (reset_n && edge_count !== last)
      chk_cnt(edge_count, q.size() > 0 ? q.pop_front() : ~edge_count);
    last = edge_count;
  end
  initial begin
    cyc(20000);
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(29));
    md = '{7'h00, 7'h01, 7'h04, 7'h0B, 7'h0C, 7'h65, 7'h68, 7'h6F, 7'h70, 7'h02};
    mk_in = '{14'h01F4, 14'h0000, 14'h2001, 14'h2000, 14'h0001};
    mk_ex = '{14'h01F4, 14'h01F4, 14'h01F4, 14'h2000, 14'h0001};
    rst(7'h00);
    chk_val(division_marks, 14'h0400);
    marks_load = 1'b1;
    // back to back loads, out of range ones ignored
    foreach (mk_in[i]) begin
      marks_value = mk_in[i];
      cyc(1);
      chk_val(division_marks, mk_ex[i]);
    end
    marks_load = 1'b0;
    foreach (md[i]) begin
      rst(md[i]);
      chk_val(track_a_free, md[i] == 7'h00 || md[i] == 7'h02);
      chk_val(track_b_free, !(md[i] inside {7'h01, 7'h04, 7'h65, 7'h68}));
      chk_val(mode_bad, md[i] == 7'h02);
      repeat (14) mv(1'($urandom_range(1)));
      // off mode: walk home with nothing counted, so reset sees no edge
      sensor_mode = 7'h00;
      cyc(1);
      chk_val(track_a_free, 14'h0001);
      chk_val(track_b_free, 14'h0001);
      while (ph != 0) mv(1'b0);
      chk_cnt(q.size(), 32'h00000000);
    end
    wrap_up();
  end
endmodule : isse_eval_tb
`default_nettype wire
